// ---- rtl/byte_fifo.v ----
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;
   assign in_ready  = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tape_framer_regs.vh ----
// constants for the tape record framer
`ifndef TAPE_FRAMER_REGS_VH
`define TAPE_FRAMER_REGS_VH
`define TF_LEADER_BYTE   8'h55
`define TF_SYNC_BYTE     8'h3C
`define TF_TRAILER_BYTE  8'h55
`define TF_TYPE_NAME     8'h00
`define TF_TYPE_DATA     8'h01
`define TF_TYPE_EOF      8'hFF
`define TF_NAME_LEN      8'h0F
`define TF_LEADER_COUNT  8'h80
`define TF_KIND_BASIC    8'h00
`define TF_KIND_DATA     8'h01
`define TF_KIND_MCODE    8'h02
`define TF_TEXT_BINARY   8'h00
`define TF_TEXT_CHAR     8'hFF
`define TF_GAP_NONE      8'h01
`define TF_GAP_SPLIT     8'hFF
`define TF_BLANK_MS      500
`define TF_CLK_KHZ       25000
`define TF_BLANK_CYCLES  (`TF_BLANK_MS * `TF_CLK_KHZ)
`endif

// ---- rtl/tape_record_framer.v ----
// tape file framer and block deframer
`timescale 1ns/1ns
`default_nettype none
`include "tape_framer_regs.vh"
module tape_record_framer #(
   parameter BLANK_CYCLES = `TF_BLANK_CYCLES,
   parameter FIFO_DEPTH   = 8
) (
   input  wire        core_clk,
   input  wire        sys_rst,
   // transmit command and header fields
   input  wire        tx_start,
   input  wire [63:0] tx_name,
   input  wire [7:0]  tx_kind,
   input  wire        tx_text,
   input  wire        tx_gaps,
   input  wire [15:0] tx_exec_addr,
   input  wire [15:0] tx_load_addr,
   output wire        tx_busy,
   // transmit data blocks from host
   input  wire [7:0]  tx_blk_len,
   input  wire        tx_blk_last,
   input  wire [7:0]  tx_data,
   input  wire        tx_data_valid,
   output wire        tx_data_ready,
   // byte stream to the modulator
   output reg  [7:0]  mod_byte,
   output reg         mod_valid,
   input  wire        mod_ready,
   output reg         mod_blank,
   // byte stream from the demodulator
   input  wire [7:0]  dem_byte,
   input  wire        dem_valid,
   // received payload to host
   output reg  [7:0]  rx_data,
   output reg         rx_data_valid,
   output reg  [7:0]  rx_type,
   output reg         rx_block_ok,
   output reg         rx_block_err
);
   // transmit states
   localparam [10:0] T_IDLE  = 11'h001;
   localparam [10:0] T_LEAD  = 11'h002;
   localparam [10:0] T_PRE   = 11'h004;
   localparam [10:0] T_SYNC  = 11'h008;
   localparam [10:0] T_TYPE  = 11'h010;
   localparam [10:0] T_LEN   = 11'h020;
   localparam [10:0] T_PAY   = 11'h040;
   localparam [10:0] T_SUM   = 11'h080;
   localparam [10:0] T_TRL   = 11'h100;
   localparam [10:0] T_BLANK = 11'h200;
   localparam [10:0] T_NEXT  = 11'h400;
   // receive states
   localparam [6:0] R_HUNT = 7'h01;
   localparam [6:0] R_SYNC = 7'h02;
   localparam [6:0] R_TYPE = 7'h04;
   localparam [6:0] R_LEN  = 7'h08;
   localparam [6:0] R_PAY  = 7'h10;
   localparam [6:0] R_SUM  = 7'h20;
   localparam [6:0] R_TRL  = 7'h40;

   reg [10:0] tst_ff;
   reg [7:0]  tcnt_ff;
   reg [7:0]  tsum_ff;
   reg [7:0]  ttype_ff;
   reg [7:0]  tlen_ff;
   reg        tsecond_ff;
   reg        tlast_ff;
   reg [31:0] blank_ff;
   reg [6:0]  rst_ff;
   reg [7:0]  rcnt_ff;
   reg [7:0]  rsum_ff;
   reg [7:0]  rtype_ff;
   reg [7:0]  rbuf [0:255];
   reg [7:0]  rout_ff;
   reg [7:0]  rlen_ff;
   reg        rdrain_ff;
   wire [7:0] f_data;
   wire       f_valid;
   wire       f_pop;
   wire       mod_take;

   // filename payload byte by index
   function [7:0] name_byte;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: name_byte = tx_name[63:56];
            4'h1: name_byte = tx_name[55:48];
            4'h2: name_byte = tx_name[47:40];
            4'h3: name_byte = tx_name[39:32];
            4'h4: name_byte = tx_name[31:24];
            4'h5: name_byte = tx_name[23:16];
            4'h6: name_byte = tx_name[15:8];
            4'h7: name_byte = tx_name[7:0];
            4'h8: name_byte = tx_kind;
            4'h9: name_byte = tx_text ? `TF_TEXT_CHAR : `TF_TEXT_BINARY;
            4'hA: name_byte = tx_gaps ? `TF_GAP_SPLIT : `TF_GAP_NONE;
            4'hB: name_byte = tx_exec_addr[15:8];
            4'hC: name_byte = tx_exec_addr[7:0];
            4'hD: name_byte = tx_load_addr[15:8];
            4'hE: name_byte = tx_load_addr[7:0];
            default: name_byte = 8'h00;
         endcase
      end
   endfunction

   // known block type codes
   function type_known;
      input [7:0] t;
      begin
         type_known = (t == `TF_TYPE_DATA) || (t == `TF_TYPE_EOF) || (t == `TF_TYPE_NAME);
      end
   endfunction

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_data   (tx_data),
      .in_valid  (tx_data_valid),
      .in_ready  (tx_data_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   // stays busy until the last trailer byte has been taken
   assign tx_busy  = (tst_ff != T_IDLE) | mod_valid;
   assign mod_take = mod_valid & mod_ready;
   // payload byte leaves the fifo only when the modulator has room
   assign f_pop    = (tst_ff == T_PAY) && (ttype_ff == `TF_TYPE_DATA) && f_valid
                     && (!mod_valid || mod_ready);

   // transmit sequencer
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tst_ff     <= T_IDLE;
         tcnt_ff    <= 8'h00;
         tsum_ff    <= 8'h00;
         ttype_ff   <= 8'h00;
         tlen_ff    <= 8'h00;
         tsecond_ff <= 1'b0;
         tlast_ff   <= 1'b0;
         blank_ff   <= 32'h00000000;
         mod_byte   <= 8'h00;
         mod_valid  <= 1'b0;
         mod_blank  <= 1'b0;
      end else begin
         if (mod_take) begin
            mod_valid <= 1'b0;
         end
         case (tst_ff)
            T_IDLE: begin
               if (tx_start && !mod_valid) begin
                  tst_ff     <= T_LEAD;
                  tcnt_ff    <= 8'h00;
                  tsecond_ff <= 1'b0;
                  ttype_ff   <= `TF_TYPE_NAME;
                  tlen_ff    <= `TF_NAME_LEN;
               end
            end
            T_LEAD: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= `TF_LEADER_BYTE;
                  mod_valid <= 1'b1;
                  tcnt_ff   <= tcnt_ff + 8'h01;
                  if (tcnt_ff == `TF_LEADER_COUNT - 8'h01) begin
                     tst_ff <= tsecond_ff ? T_NEXT : T_PRE;
                  end
               end
            end
            T_NEXT: begin
               // next data block: wait for its first byte or end flag
               if (tx_blk_last) begin
                  ttype_ff <= `TF_TYPE_EOF;
                  tlen_ff  <= 8'h00;
                  tlast_ff <= 1'b1;
                  tst_ff   <= T_PRE;
               end else if (f_valid) begin
                  ttype_ff <= `TF_TYPE_DATA;
                  tlen_ff  <= tx_blk_len;
                  tlast_ff <= 1'b0;
                  tst_ff   <= T_PRE;
               end
            end
            T_PRE: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= `TF_LEADER_BYTE;
                  mod_valid <= 1'b1;
                  tst_ff    <= T_SYNC;
               end
            end
            T_SYNC: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= `TF_SYNC_BYTE;
                  mod_valid <= 1'b1;
                  tst_ff    <= T_TYPE;
               end
            end
            T_TYPE: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= ttype_ff;
                  mod_valid <= 1'b1;
                  tsum_ff   <= ttype_ff;
                  tst_ff    <= T_LEN;
               end
            end
            T_LEN: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= tlen_ff;
                  mod_valid <= 1'b1;
                  tsum_ff   <= tsum_ff + tlen_ff;
                  tcnt_ff   <= 8'h00;
                  tst_ff    <= (tlen_ff == 8'h00) ? T_SUM : T_PAY;
               end
            end
            T_PAY: begin
               if (ttype_ff == `TF_TYPE_NAME) begin
                  if (!mod_valid || mod_ready) begin
                     mod_byte  <= name_byte(tcnt_ff[3:0]);
                     mod_valid <= 1'b1;
                     tsum_ff   <= tsum_ff + name_byte(tcnt_ff[3:0]);
                     tcnt_ff   <= tcnt_ff + 8'h01;
                     if (tcnt_ff == tlen_ff - 8'h01) begin
                        tst_ff <= T_SUM;
                     end
                  end
               end else if (f_pop) begin
                  mod_byte  <= f_data;
                  mod_valid <= 1'b1;
                  tsum_ff   <= tsum_ff + f_data;
                  tcnt_ff   <= tcnt_ff + 8'h01;
                  if (tcnt_ff == tlen_ff - 8'h01) begin
                     tst_ff <= T_SUM;
                  end
               end
            end
            T_SUM: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= tsum_ff;
                  mod_valid <= 1'b1;
                  tst_ff    <= T_TRL;
               end
            end
            T_TRL: begin
               if (!mod_valid || mod_ready) begin
                  mod_byte  <= `TF_TRAILER_BYTE;
                  mod_valid <= 1'b1;
                  if (ttype_ff == `TF_TYPE_NAME) begin
                     tst_ff   <= T_BLANK;
                     blank_ff <= 32'h00000000;
                  end else if (tlast_ff) begin
                     tst_ff <= T_IDLE;
                  end else begin
                     tst_ff <= T_NEXT;
                  end
               end
            end
            T_BLANK: begin
               // hold the line quiet once the trailer has left
               if (!mod_valid) begin
                  mod_blank <= 1'b1;
                  blank_ff  <= blank_ff + 32'h00000001;
                  if (blank_ff == BLANK_CYCLES) begin
                     mod_blank  <= 1'b0;
                     tsecond_ff <= 1'b1;
                     tcnt_ff    <= 8'h00;
                     tst_ff     <= T_LEAD;
                  end
               end
            end
            default: tst_ff <= T_IDLE;
         endcase
      end
   end

   // received block bytes are held until the block proves good
   always @(posedge core_clk) begin
      if (dem_valid && (rst_ff == R_PAY)) begin
         rbuf[rcnt_ff] <= dem_byte;
      end
   end

   // receive checker
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_ff        <= R_HUNT;
         rcnt_ff       <= 8'h00;
         rsum_ff       <= 8'h00;
         rtype_ff      <= 8'h00;
         rlen_ff       <= 8'h00;
         rout_ff       <= 8'h00;
         rdrain_ff     <= 1'b0;
         rx_data       <= 8'h00;
         rx_data_valid <= 1'b0;
         rx_type       <= 8'h00;
         rx_block_ok   <= 1'b0;
         rx_block_err  <= 1'b0;
      end else begin
         rx_block_ok   <= 1'b0;
         rx_block_err  <= 1'b0;
         rx_data_valid <= 1'b0;
         // release a checked block one byte a cycle
         if (rdrain_ff) begin
            if (rout_ff == rlen_ff) begin
               rdrain_ff   <= 1'b0;
               rx_block_ok <= 1'b1;
            end else begin
               rx_data       <= rbuf[rout_ff];
               rx_data_valid <= 1'b1;
               rout_ff       <= rout_ff + 8'h01;
            end
         end
         if (dem_valid) begin
            case (rst_ff)
               R_HUNT: begin
                  if (dem_byte == `TF_LEADER_BYTE) begin
                     rst_ff <= R_SYNC;
                  end
               end
               R_SYNC: begin
                  if (dem_byte == `TF_SYNC_BYTE) begin
                     rst_ff <= R_TYPE;
                  end else if (dem_byte != `TF_LEADER_BYTE) begin
                     rst_ff       <= R_HUNT;
                     rx_block_err <= 1'b1;
                  end
               end
               R_TYPE: begin
                  if (type_known(dem_byte)) begin
                     rtype_ff <= dem_byte;
                     rsum_ff  <= dem_byte;
                     rst_ff   <= R_LEN;
                  end else begin
                     rst_ff       <= R_HUNT;
                     rx_block_err <= 1'b1;
                  end
               end
               R_LEN: begin
                  rlen_ff <= dem_byte;
                  rsum_ff <= rsum_ff + dem_byte;
                  rcnt_ff <= 8'h00;
                  if ((rtype_ff == `TF_TYPE_EOF && dem_byte != 8'h00) ||
                      (rtype_ff == `TF_TYPE_NAME && dem_byte != `TF_NAME_LEN)) begin
                     rst_ff       <= R_HUNT;
                     rx_block_err <= 1'b1;
                  end else begin
                     rst_ff <= (dem_byte == 8'h00) ? R_SUM : R_PAY;
                  end
               end
               R_PAY: begin
                  rsum_ff <= rsum_ff + dem_byte;
                  rcnt_ff <= rcnt_ff + 8'h01;
                  if (rcnt_ff == rlen_ff - 8'h01) begin
                     rst_ff <= R_SUM;
                  end
               end
               R_SUM: begin
                  if (dem_byte == rsum_ff) begin
                     rst_ff <= R_TRL;
                  end else begin
                     rst_ff       <= R_HUNT;
                     rx_block_err <= 1'b1;
                  end
               end
               R_TRL: begin
                  rst_ff <= R_HUNT;
                  if (dem_byte == `TF_TRAILER_BYTE) begin
                     rx_type   <= rtype_ff;
                     rout_ff   <= 8'h00;
                     rdrain_ff <= 1'b1;
                  end else begin
                     rx_block_err <= 1'b1;
                  end
               end
               default: rst_ff <= R_HUNT;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tape_framer_properties.sv ----
// port assertions for the tape record framer
`timescale 1ns/1ns
`default_nettype none
module tape_framer_properties #(
   parameter BLANK_CYCLES = 20
) (
   input wire       core_clk,
   input wire       sys_rst,
   input wire       tx_start,
   input wire       tx_busy,
   input wire [7:0] mod_byte,
   input wire       mod_valid,
   input wire       mod_ready,
   input wire       mod_blank,
   input wire       rx_data_valid,
   input wire [7:0] rx_type,
   input wire       rx_block_ok,
   input wire       rx_block_err
);
   logic [31:0] blank_cnt_ff;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blank_cnt_ff <= 32'h0;
      end else if (mod_blank) begin
         blank_cnt_ff <= blank_cnt_ff + 32'h1;
      end else begin
         blank_cnt_ff <= 32'h0;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   a_first_leader: assert property (
      tx_start && !tx_busy |-> ##[1:2] (mod_valid && mod_byte == 8'h55))
      else $error("file did not open with a leader byte");
   a_byte_holds: assert property (
      mod_valid && !mod_ready |=> mod_valid && $stable(mod_byte))
      else $error("byte dropped before it was taken");
   a_blank_silent: assert property (
      mod_blank |-> !mod_valid && tx_busy)
      else $error("byte offered during the blank gap");
   a_blank_length: assert property (
      $fell(mod_blank) |-> blank_cnt_ff == BLANK_CYCLES)
      else $error("blank gap has the wrong length");
   a_leader_resumes: assert property (
      $fell(mod_blank) |-> ##[0:2] (mod_valid && mod_byte == 8'h55))
      else $error("no leader after the blank gap");
   a_idle_quiet: assert property (
      !tx_busy && !$past(tx_busy) |-> !mod_valid && !mod_blank)
      else $error("output active while idle");
   a_payload_type: assert property (
      rx_data_valid |-> rx_type == 8'h00 || rx_type == 8'h01)
      else $error("payload delivered for a block without payload");
   a_ok_type: assert property (
      rx_block_ok |-> rx_type inside {8'h00, 8'h01, 8'hFF})
      else $error("good block with unknown type");
   a_ok_apart: assert property (
      rx_block_ok |-> !rx_block_err && !rx_data_valid)
      else $error("good block overlaps error or data");
   a_drain_ends: assert property (
      $fell(rx_data_valid) |-> rx_block_ok)
      else $error("payload drain not closed by good block");
endmodule
bind tape_record_framer tape_framer_properties #(.BLANK_CYCLES(BLANK_CYCLES)) i_props (
   .core_clk(core_clk), .sys_rst(sys_rst), .tx_start(tx_start), .tx_busy(tx_busy),
   .mod_byte(mod_byte), .mod_valid(mod_valid), .mod_ready(mod_ready),
   .mod_blank(mod_blank), .rx_data_valid(rx_data_valid), .rx_type(rx_type),
   .rx_block_ok(rx_block_ok), .rx_block_err(rx_block_err)
);
`default_nettype wire

// ---- testbench/tape_modulator_model.sv ----
// modulator model that takes framed bytes with random stalls
`timescale 1ns/1ns
`default_nettype none
module tape_modulator_model (
   input  wire        core_clk,
   input  wire        sys_rst,
   input  wire  [7:0] mod_byte,
   input  wire        mod_valid,
   output logic       mod_ready,
   output logic [7:0] got_byte,
   output logic       got_stb
);
   integer seed;
   initial begin
      seed = 81064;
      mod_ready = 1'b0;
      got_byte = 8'h00;
      got_stb = 1'b0;
   end
   // bytes are taken whole, in order, one per ready edge
   always @(posedge core_clk) begin
      got_stb <= mod_valid && mod_ready && !sys_rst;
      got_byte <= mod_byte;
      mod_ready <= #1 (($random(seed) & 3) != 0);
   end
endmodule
`default_nettype wire

// ---- testbench/tape_record_framer_tb.sv ----
// self-checking bench for the tape record framer
`timescale 1ns/1ns
`default_nettype none
`include "tape_framer_regs.vh"
module tape_record_framer_tb;
   localparam BLANK = 20;
   logic        core_clk, sys_rst, tx_start, tx_text, tx_gaps, tx_blk_last;
   logic        tx_data_valid, dem_valid;
   logic [7:0]  tx_kind, tx_blk_len, tx_data, dem_byte, got_byte;
   logic [63:0] tx_name;
   logic [15:0] tx_exec_addr, tx_load_addr;
   wire         tx_busy, tx_data_ready, mod_valid, mod_ready, mod_blank, got_stb;
   wire         rx_data_valid, rx_block_ok, rx_block_err;
   wire  [7:0]  mod_byte, rx_data, rx_type;
   integer      seed, n_fail, cmp_count, blank_n, at_blank, i, k;
   logic [7:0]  exp_q[$], got_q[$], fifo_q[$], pl_q[$];
   logic [15:0] rx_exp[$], rx_got[$];
   tape_record_framer #(.BLANK_CYCLES(BLANK), .FIFO_DEPTH(8)) i_tape_record_framer (
      .core_clk(core_clk), .sys_rst(sys_rst), .tx_start(tx_start), .tx_name(tx_name),
      .tx_kind(tx_kind), .tx_text(tx_text), .tx_gaps(tx_gaps), .tx_busy(tx_busy),
      .tx_exec_addr(tx_exec_addr), .tx_load_addr(tx_load_addr),
      .tx_blk_len(tx_blk_len), .tx_blk_last(tx_blk_last), .tx_data(tx_data),
      .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
      .mod_byte(mod_byte), .mod_valid(mod_valid), .mod_ready(mod_ready),
      .mod_blank(mod_blank), .dem_byte(dem_byte), .dem_valid(dem_valid),
      .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_type(rx_type),
      .rx_block_ok(rx_block_ok), .rx_block_err(rx_block_err));
   tape_modulator_model i_tape_modulator_model (
      .core_clk(core_clk), .sys_rst(sys_rst), .mod_byte(mod_byte), .mod_valid(mod_valid),
      .mod_ready(mod_ready), .got_byte(got_byte), .got_stb(got_stb));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (got_stb === 1'b1) got_q.push_back(got_byte);
      if (mod_blank === 1'b1) begin
         if (blank_n == 0) at_blank = got_q.size();
         blank_n = blank_n + 1;
      end
      if (rx_data_valid === 1'b1) rx_got.push_back({8'h01, rx_data});
      if (rx_block_ok === 1'b1) rx_got.push_back({8'h02, rx_type});
      if (rx_block_err === 1'b1) rx_got.push_back(16'h0300);
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task bail;
      check(16'h0, 16'h1);
      stop_test();
   endtask
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   task add_blk(input logic [7:0] t);
      logic [7:0] s;
      integer j;
      s = t + 8'(pl_q.size());
      exp_q.push_back(`TF_LEADER_BYTE);
      exp_q.push_back(`TF_SYNC_BYTE);
      exp_q.push_back(t);
      exp_q.push_back(8'(pl_q.size()));
      for (j = 0; j < pl_q.size(); j++) begin
         exp_q.push_back(pl_q[j]);
         s = s + pl_q[j];
      end
      exp_q.push_back(s);
      exp_q.push_back(`TF_TRAILER_BYTE);
   endtask
   task data_blk(input integer lo, input integer hi);
      pl_q.delete();
      for (i = lo; i < hi; i++) pl_q.push_back(fifo_q[i]);
      add_blk(`TF_TYPE_DATA);
   endtask
   task run_file(input integer f);
      integer n, l1;
      tx_name = {$random(seed), $random(seed)};
      tx_kind = f[7:0];
      tx_text = (f == 1);
      tx_gaps = (f == 2);
      tx_exec_addr = $random(seed);
      tx_load_addr = $random(seed);
      l1 = 3 * f;
      exp_q.delete();
      got_q.delete();
      fifo_q.delete();
      blank_n = 0;
      n = 0;
      for (i = 0; i < 9; i++) begin
         tx_data = $random(seed);
         tx_data_valid = 1'b1;
         @(negedge core_clk);
         if (tx_data_ready === 1'b1) fifo_q.push_back(tx_data);
         tick();
      end
      tx_data_valid = 1'b0;
      check(16'(fifo_q.size()), 16'h8);
      repeat (128) exp_q.push_back(`TF_LEADER_BYTE);
      pl_q.delete();
      for (i = 7; i >= 0; i--) pl_q.push_back(tx_name[i*8 +: 8]);
      pl_q.push_back(tx_kind);
      pl_q.push_back(tx_text ? `TF_TEXT_CHAR : `TF_TEXT_BINARY);
      pl_q.push_back(tx_gaps ? `TF_GAP_SPLIT : `TF_GAP_NONE);
      pl_q.push_back(tx_exec_addr[15:8]);
      pl_q.push_back(tx_exec_addr[7:0]);
      pl_q.push_back(tx_load_addr[15:8]);
      pl_q.push_back(tx_load_addr[7:0]);
      add_blk(`TF_TYPE_NAME);
      repeat (128) exp_q.push_back(`TF_LEADER_BYTE);
      data_blk(0, l1);
      data_blk(l1, 8);
      pl_q.delete();
      add_blk(`TF_TYPE_EOF);
      tx_blk_len = l1;
      tx_blk_last = 1'b0;
      tx_start = 1'b1;
      tick();
      for (n = 0; n < 20000 && got_q.size() < exp_q.size(); n++) begin
         tx_start = (n == 5);
         if (got_q.size() > 277) tx_blk_len = 8 - l1;
         if (got_q.size() > 283 + l1) tx_blk_last = 1'b1;
         tick();
      end
      if (n == 20000) bail();
      repeat (12) tick();
      check(16'(got_q.size()), 16'(exp_q.size()));
      for (i = 0; i < exp_q.size(); i++) check(got_q[i], exp_q[i]);
      check(16'(at_blank), 16'd149);
      check(16'(blank_n), 16'(BLANK));
      check({15'h0, tx_busy}, 16'h0);
      $display("transmit file %0d done", f);
   endtask
   task send(input logic [7:0] b);
      dem_byte = b;
      dem_valid = 1'b1;
      tick();
   endtask
   task rx_case(input integer c);
      logic [7:0] t, l, s, p;
      integer j, n;
      t = (c == 1 || c == 7) ? 8'h00 : (c == 2) ? 8'hFF : (c == 6) ? 8'h02 : 8'h01;
      l = (c == 1) ? 8'h0F : (c == 2) ? 8'h00 : (c == 7) ? 8'h0E : 8'h01 + ($random(seed) & 5);
      rx_exp.delete();
      rx_got.delete();
      repeat (1 + c % 3) send(`TF_LEADER_BYTE);
      send((c == 3) ? 8'h3A : `TF_SYNC_BYTE);
      if (c != 3) send(t);
      if (c != 3 && c != 6) send(l);
      if (c < 3 || c == 4 || c == 5) begin
         s = t + l;
         for (j = 0; j < l; j++) begin
            p = $random(seed);
            s = s + p;
            send(p);
            if (c < 3) rx_exp.push_back({8'h01, p});
         end
         send((c == 4) ? ~s : s);
         send((c == 5) ? 8'h54 : 8'h55);
      end
      dem_valid = 1'b0;
      dem_byte = ~dem_byte;
      rx_exp.push_back((c < 3) ? {8'h02, t} : 16'h0300);
      for (n = 0; n < 60 && rx_got.size() < rx_exp.size(); n++) tick();
      if (n == 60) bail();
      repeat (6) tick();
      check(16'(rx_got.size()), 16'(rx_exp.size()));
      for (j = 0; j < rx_exp.size(); j++) check(rx_got[j], rx_exp[j]);
      $display("receive case %0d done", c);
   endtask
   initial begin
      seed = 81064;
      n_fail = 0;
      cmp_count = 0;
      blank_n = 0;
      at_blank = 0;
      sys_rst = 1'b1;
      {tx_start, tx_text, tx_gaps, tx_blk_last, tx_data_valid, dem_valid} = 6'h0;
      {tx_kind, tx_blk_len, tx_data, dem_byte} = 32'h0;
      tx_name = 64'h0;
      {tx_exec_addr, tx_load_addr} = 32'h0;
      repeat (5) tick();
      sys_rst = 1'b0;
      check({15'h0, tx_data_ready}, 16'h1);
      for (k = 0; k < 3; k++) run_file(k);
      for (k = 0; k < 8; k++) rx_case(k);
      stop_test();
   end
endmodule
`default_nettype wire
